// *** async_nvram_port_timing_checker.sv ***
// Purpose: Pin sequencing checks for the NVRAM host
// Assumes: One clock domain
// Notes: Figures in core_clk cycles
`timescale 1ns/1ps
module async_nvram_port_timing_checker #(
  parameter int STARTUP_CYCLES = 4
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic req_ready,
  input wire logic rd_valid,
  input wire logic [nvram_host_pkg::ADDR_W-1:0] mem_addr,
  input wire logic chip_select_n,
  input wire logic wr_strobe_n,
  input wire logic out_drive_n,
  input wire logic high_lane_n,
  input wire logic low_lane_n,
  input wire logic dq_oe_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  int cnt;
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n) cnt <= 0;
    else if (cnt < STARTUP_CYCLES) cnt <= cnt + 1;
  a_startup_quiet: assert property (
    cnt < STARTUP_CYCLES |-> !req_ready && chip_select_n && wr_strobe_n)
    else $error("access before startup");
  a_strobe_high_hold: assert property ($rose(wr_strobe_n) |=> wr_strobe_n)
    else $error("strobe high too short");
  a_select_gap: assert property ($rose(chip_select_n) |=> chip_select_n [*2])
    else $error("select gap too short");
  a_read_no_strobe: assert property (!chip_select_n && !out_drive_n |-> wr_strobe_n)
    else $error("strobe low in read");
  a_write_window: assert property (
    !wr_strobe_n |-> !chip_select_n && !dq_oe_n && out_drive_n)
    else $error("write window bad");
  a_addr_setup: assert property (
    $fell(wr_strobe_n) |-> $stable(mem_addr))
    else $error("address moved at write start");
  a_addr_held: assert property (
    $rose(wr_strobe_n) |-> $stable(mem_addr) ##1 $stable(mem_addr))
    else $error("address moved at write end");
  a_lanes_together: assert property (
    $fell(high_lane_n) && !low_lane_n |-> $fell(low_lane_n))
    else $error("lane skew");
  a_read_length: assert property (
    $fell(chip_select_n) && !out_drive_n |-> !rd_valid [*4] ##1 rd_valid)
    else $error("read length wrong");
  a_write_pulse: assert property ($fell(wr_strobe_n) |=> wr_strobe_n && chip_select_n)
    else $error("write pulse wrong");
  cover property ($fell(wr_strobe_n));
  cover property ($fell(chip_select_n) && !out_drive_n && high_lane_n);
  cover property ($fell(chip_select_n) && !out_drive_n && !high_lane_n);
endmodule : async_nvram_port_timing_checker

// *** async_nvram_port_timing_tb.sv ***
// Purpose: Self-checking bench for the NVRAM host
// Assumes: Startup wait shortened to 4 cycles
// Notes: Device side is nvram_model
`timescale 1ns/1ps
module async_nvram_port_timing_tb;
  import nvram_host_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  req_t req = '0;
  logic req_ready, rd_valid, chip_select_n, wr_strobe_n, out_drive_n;
  logic high_lane_n, low_lane_n, dq_oe_n;
  logic [DATA_W-1:0] rd_data, dq_out, dq_in;
  logic [ADDR_W-1:0] mem_addr;
  pins_t pins;
  int error_cnt = 0;
  int num_checks = 0;
  always #25 core_clk = ~core_clk;
  assign pins = '{mem_addr, chip_select_n, wr_strobe_n, out_drive_n,
                  high_lane_n, low_lane_n, dq_out, dq_oe_n};
  nvram_host #(
    .STARTUP_CYCLES(4)
  ) dut_u (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .req_valid(req_valid),
    .req_ready(req_ready),
    .req(req),
    .rd_valid(rd_valid),
    .rd_data(rd_data),
    .mem_addr(mem_addr),
    .chip_select_n(chip_select_n),
    .wr_strobe_n(wr_strobe_n),
    .out_drive_n(out_drive_n),
    .high_lane_n(high_lane_n),
    .low_lane_n(low_lane_n),
    .dq_out(dq_out),
    .dq_oe_n(dq_oe_n),
    .dq_in(dq_in)
  );
  nvram_model mem_u (.p(pins), .dq_in(dq_in));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // Read: d is the expected word, compared on selected lanes only
  task automatic go(input logic w, input logic [1:0] l, input logic [19:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(negedge core_clk);
    req = '{w, l, a, d};
    req_valid = 1'b1;
    // Ready is looked at between edges; the next rising edge takes the request
    while (req_ready !== 1'b1 && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    @(negedge core_clk);
    req_valid = 1'b0;
    chk(n < 40, 1'b1);
    n = 0;
    while (!w && rd_valid !== 1'b1 && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    if (!w) chk(rd_valid, 1'b1);
    if (!w) chk(rd_data & {{8{~l[1]}}, {8{~l[0]}}}, d & {{8{~l[1]}}, {8{~l[0]}}});
  endtask : go
  task automatic t_startup;
    repeat (2) @(negedge core_clk);
    chk({req_ready, chip_select_n, wr_strobe_n}, 3'b011);
    repeat (4) @(negedge core_clk);
    chk(req_ready, 1'b1);
  endtask : t_startup
  task automatic t_lanes;
    go(1'b1, 2'b00, 20'h1_2345, 16'hBEEF);
    go(1'b0, 2'b00, 20'h1_2345, 16'hBEEF);
    go(1'b1, 2'b10, 20'h1_2345, 16'h0011);
    go(1'b1, 2'b01, 20'h1_2345, 16'h2200);
    go(1'b0, 2'b00, 20'h1_2345, 16'h2211);
    go(1'b0, 2'b10, 20'h1_2345, 16'h0011);
    go(1'b0, 2'b01, 20'h1_2345, 16'h2200);
  endtask : t_lanes
  task automatic t_b2b;
    go(1'b1, 2'b00, 20'h0_0000, 16'h1234);
    go(1'b1, 2'b00, 20'hF_FFFF, 16'hCAFE);
    go(1'b0, 2'b00, 20'h0_0000, 16'h1234);
    go(1'b0, 2'b00, 20'hF_FFFF, 16'hCAFE);
  endtask : t_b2b
  task automatic t_reset_mid;
    @(negedge core_clk);
    req = '{1'b1, 2'b00, 20'h0_0001, 16'h5555};
    req_valid = 1'b1;
    repeat (3) @(negedge core_clk);
    rst_n = 1'b0;
    req_valid = 1'b0;
    @(negedge core_clk);
    chk({chip_select_n, wr_strobe_n, dq_oe_n}, 3'b111);
    rst_n = 1'b1;
    @(negedge core_clk);
    chk(req_ready, 1'b0);
    go(1'b0, 2'b00, 20'hF_FFFF, 16'hCAFE);
  endtask : t_reset_mid
  task automatic complete_run;
    if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  initial begin
    repeat (4) @(negedge core_clk);
    rst_n = 1'b1;
    t_startup();
    t_lanes();
    t_b2b();
    t_reset_mid();
    complete_run();
  end
  initial begin
    #100000;
    error_cnt++;
    complete_run();
  end
endmodule : async_nvram_port_timing_tb
bind nvram_host async_nvram_port_timing_checker #(
  .STARTUP_CYCLES(STARTUP_CYCLES)
) chk_u (
  .core_clk(core_clk),
  .rst_n(rst_n),
  .req_ready(req_ready),
  .rd_valid(rd_valid),
  .mem_addr(mem_addr),
  .chip_select_n(chip_select_n),
  .wr_strobe_n(wr_strobe_n),
  .out_drive_n(out_drive_n),
  .high_lane_n(high_lane_n),
  .low_lane_n(low_lane_n),
  .dq_oe_n(dq_oe_n)
);

// *** nvram_host.sv ***
// Purpose: Host controller driving an async 1M x 16 NVRAM through its pins
// Assumes: Device holds RL22 decode; 50 ns clock makes every ns figure one cycle
// Notes: One access at a time; request taken on req_valid and req_ready
`timescale 1ns/1ps
module nvram_host
  import nvram_host_pkg::*;
#(
  parameter int STARTUP_CYCLES = CYC_STARTUP
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire nvram_host_pkg::req_t req,
  output logic rd_valid,
  output logic [nvram_host_pkg::DATA_W-1:0] rd_data,
  output logic [nvram_host_pkg::ADDR_W-1:0] mem_addr,
  output logic chip_select_n,
  output logic wr_strobe_n,
  output logic out_drive_n,
  output logic high_lane_n,
  output logic low_lane_n,
  output logic [nvram_host_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe_n,
  input wire logic [nvram_host_pkg::DATA_W-1:0] dq_in
);
  import nvram_host_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_SETUP = 3'b001,
    S_ACTIVE = 3'b011,
    S_RECOVER = 3'b010,
    S_GAP = 3'b110
  } state_t;

  typedef struct packed {
    state_t st;
    logic [CNT_W-1:0] cnt;
    logic write;
    pins_t pins;
    logic rd_valid;
    logic [DATA_W-1:0] rd_data;
    logic [DATA_W-1:0] s1;
    logic [DATA_W-1:0] s2;
    logic [DATA_W-1:0] s3;
    logic [DATA_W-1:0] settled;
  } core_t;

  localparam pins_t PINS_IDLE = '{addr: ADDR_ZERO, chip_select_n: 1'b1, wr_strobe_n: 1'b1,
    out_drive_n: 1'b1, high_lane_n: 1'b1, low_lane_n: 1'b1, dq_out: DATA_ZERO, dq_oe_n: 1'b1};

  core_t r;
  core_t next_r;
  logic started;

  startup_timer #(
    .COUNT(STARTUP_CYCLES)
  ) u_startup (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .done(started)
  );

  // Accept only once started and idle; select and strobe stay high until then
  assign req_ready = started && (r.st == S_IDLE); // [RL20]

  always_comb begin
    next_r = r;
    next_r.rd_valid = 1'b0;
    // Read data crosses from the pins through three stages
    next_r.s1 = dq_in;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    // A bit counts once the last two stages agree; a moving bit keeps its old value
    next_r.settled = (r.s3 & ~(r.s2 ^ r.s3)) | (r.settled & (r.s2 ^ r.s3));
    unique case (r.st)
      S_IDLE: begin
        if (req_valid && req_ready) begin
          // Address and lanes set a cycle before the window opens
          next_r.pins.addr = req.addr; // [RL12] [RL18]
          next_r.write = req.write;
          next_r.pins.high_lane_n = req.lanes_n[1]; // [RL21]
          next_r.pins.low_lane_n = req.lanes_n[0]; // [RL21]
          next_r.pins.dq_out = req.wdata;
          next_r.pins.dq_oe_n = !req.write; // [RL13]
          next_r.cnt = 8'(CYC_SETUP - 1);
          next_r.st = S_SETUP;
        end
      end
      S_SETUP: begin
        if (r.cnt == CNT_ZERO) begin
          next_r.pins.chip_select_n = 1'b0; // [RL1]
          // Strobe high through reads; output enable never with a write
          next_r.pins.wr_strobe_n = !r.write; // [RL5]
          next_r.pins.out_drive_n = r.write; // [RL2]
          next_r.cnt = r.write ? 8'(CYC_PULSE - 1) : 8'(CYC_READ + 2);
          next_r.st = S_ACTIVE;
        end else begin
          next_r.cnt = r.cnt - 8'h01;
        end
      end
      S_ACTIVE: begin
        if (r.cnt == CNT_ZERO) begin
          // Strobe and select rise together ending the window
          next_r.pins.chip_select_n = 1'b1; // [RL14]
          next_r.pins.wr_strobe_n = 1'b1; // [RL1]
          next_r.pins.out_drive_n = 1'b1;
          if (!r.write) begin
            // Sampled after access time plus the three-stage delay
            next_r.rd_data = next_r.settled; // [RL6]
            next_r.rd_valid = 1'b1;
          end
          next_r.cnt = 8'(CYC_RECOVER - 1);
          next_r.st = S_RECOVER;
        end else begin
          next_r.cnt = r.cnt - 8'h01;
        end
      end
      S_RECOVER: begin
        // Address and data held after the window closes
        if (r.cnt == CNT_ZERO) begin // [RL23]
          next_r.pins.dq_oe_n = 1'b1;
          next_r.pins.high_lane_n = 1'b1;
          next_r.pins.low_lane_n = 1'b1;
          next_r.cnt = 8'(CYC_HIGH - 1);
          next_r.st = S_GAP;
        end else begin
          next_r.cnt = r.cnt - 8'h01;
        end
      end
      S_GAP: begin
        // Controls held high before the next fall; spaces select edges
        if (r.cnt == CNT_ZERO) begin // [RL3] [RL4]
          next_r.st = S_IDLE;
        end else begin
          next_r.cnt = r.cnt - 8'h01;
        end
      end
      default: begin
        next_r.st = S_IDLE;
        next_r.pins = PINS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{st: S_IDLE, cnt: CNT_ZERO, write: 1'b0, pins: PINS_IDLE, rd_valid: 1'b0,
        rd_data: DATA_ZERO, s1: DATA_ZERO, s2: DATA_ZERO, s3: DATA_ZERO,
        settled: DATA_ZERO};
    end else begin
      r <= next_r;
    end
  end

  assign rd_valid = r.rd_valid;
  assign rd_data = r.rd_data;
  assign mem_addr = r.pins.addr;
  assign chip_select_n = r.pins.chip_select_n;
  assign wr_strobe_n = r.pins.wr_strobe_n;
  assign out_drive_n = r.pins.out_drive_n;
  assign high_lane_n = r.pins.high_lane_n;
  assign low_lane_n = r.pins.low_lane_n;
  assign dq_out = r.pins.dq_out;
  assign dq_oe_n = r.pins.dq_oe_n;
endmodule : nvram_host

// *** nvram_host_pkg.sv ***
// Purpose: Constants and carrier types for the async NVRAM host controller
// Assumes: core_clk at 20 MHz; device pins are asynchronous SRAM style
// Notes: Pin levels are active low where the name ends in _n
// How it works
// RL1: Write lands only while select and strobe low
// RL2: Output enable low with strobe keeps device quiet
// RL3: Raised controls stay high at least 2 ns
// RL4: Select falling edges spaced by cycle time
// RL5: Strobe held high through every read
// RL6: Read data valid 35 ns after select
// RL7: Read data valid 15 ns after output enable
// RL8: Lane data valid 15 ns after lane enable
// RL9: Old data held 3 ns after address change
// RL10: Device drives no earlier than 3 ns
// RL11: Lane released within 10 ns of rise
// RL12: Address valid 20 ns before window end
// RL13: Write data driven 10 ns before window end
// RL14: Select low 15 ns in select-ended write
// RL15: Device releases bus 15 ns after strobe
// RL16: Device drives again 3 ns after strobe
// RL17: Device turn-off shorter than turn-on
// RL18: Write intervals measured from valid address
// RL19: Select-ended write keeps outputs quiet
// RL20: Hold select, strobe high for 2 ms
// RL21: Both lane enables move together
// RL22: Device decodes lanes; unselected lanes untouched
// RL23: Cycles at least 35 ns; address held 12 ns
package nvram_host_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  // Figures in ns (startup in ms)
  localparam int T_CYCLE_NS = 35;
  localparam int T_WRITE_PULSE_NS = 15;
  localparam int T_ADDR_TO_END_NS = 20;
  localparam int T_DATA_TO_END_NS = 10;
  localparam int T_RECOVERY_NS = 12;
  localparam int T_HIGH_MIN_NS = 2;
  localparam int T_READ_ACCESS_NS = 35;
  localparam int T_STARTUP_MS = 2;
  // Least times round up, at least one cycle
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_up
  localparam int CYC_PULSE = cyc_up(T_WRITE_PULSE_NS);
  localparam int CYC_READ = cyc_up(T_READ_ACCESS_NS);
  localparam int CYC_SETUP = cyc_up(T_ADDR_TO_END_NS);
  localparam int CYC_RECOVER = cyc_up(T_RECOVERY_NS);
  localparam int CYC_HIGH = cyc_up(T_HIGH_MIN_NS);
  localparam int CYC_STARTUP = (T_STARTUP_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 20'h0_0000;

  typedef struct packed {
    logic write;
    logic [1:0] lanes_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic chip_select_n;
    logic wr_strobe_n;
    logic out_drive_n;
    logic high_lane_n;
    logic low_lane_n;
    logic [DATA_W-1:0] dq_out;
    logic dq_oe_n;
  } pins_t;
endpackage : nvram_host_pkg

// *** nvram_model.sv ***
// Purpose: Pin model of the 1M x 16 NVRAM
// Assumes: Zero-delay answers
// Notes: Released lanes toggle; nothing pulls them
`timescale 1ns/1ps
module nvram_model
  import nvram_host_pkg::*;
(
  input wire pins_t p,
  output logic [DATA_W-1:0] dq_in
);
  logic [DATA_W-1:0] mem [int];
  logic [DATA_W-1:0] rd;
  logic [DATA_W-1:0] junk = 16'hA5C3;
  wire wend = p.chip_select_n | p.wr_strobe_n;
  // Strobe high required, so a write never sees us drive
  wire rd_en = !p.chip_select_n && !p.out_drive_n && p.wr_strobe_n;
  always #20 junk = ~junk;
  always @(posedge wend) begin
    if (p.dq_oe_n === 1'b0 && !mem.exists(p.addr)) mem[p.addr] = junk;
    if (p.dq_oe_n === 1'b0 && !p.low_lane_n) mem[p.addr][7:0] = p.dq_out[7:0];
    if (p.dq_oe_n === 1'b0 && !p.high_lane_n) mem[p.addr][15:8] = p.dq_out[15:8];
  end
  always @* begin
    rd = mem.exists(p.addr) ? mem[p.addr] : junk;
    dq_in = p.dq_oe_n ? junk : p.dq_out;
    if (rd_en && !p.low_lane_n) dq_in[7:0] = rd[7:0];
    if (rd_en && !p.high_lane_n) dq_in[15:8] = rd[15:8];
  end
endmodule : nvram_model

// *** startup_timer.sv ***
// Purpose: Counts the power-up wait before the first access
// Assumes: Single clock domain
// Notes: Length is a parameter so simulation can shorten it
`timescale 1ns/1ps
module startup_timer
  import nvram_host_pkg::*;
#(
  parameter int COUNT = CYC_STARTUP
) (
  input wire logic core_clk,
  input wire logic rst_n,
  output logic done
);
  import nvram_host_pkg::*;

  typedef struct packed {
    logic [31:0] cnt;
    logic done;
  } timer_t;

  timer_t r;
  timer_t next_r;

  always_comb begin
    next_r = r;
    if (!r.done) begin
      next_r.cnt = r.cnt + 32'h0000_0001;
      // Select and strobe stay high until this runs out
      next_r.done = (r.cnt >= 32'(COUNT - 1)); // [RL20]
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{cnt: 32'h0000_0000, done: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign done = r.done;
endmodule : startup_timer
